// ---- hdl/sync_serial_port.sv ----
// Synchronous serial port, master or slave, 8 or 16 bits
//
// Notes on behaviour
// - Master makes clock; slave uses master clock
// - One 16-bit shifter; 8-bit uses low byte
// - Pins swap by role; MSB first
// - One bit out, one in per clock
// - Data read gives buffer; write loads shifter
// - Buffer loads at completion only if free or read
// - Master overrun: start with buffer, shifter full
// - 8-bit load keeps buffer upper byte
// - Normal: out on falling, sample rising
// - Alternate: out on rising, sample falling
// - Idle bit sets resting clock level
// - Master clock rate from divider field
// - Leading-edge output: bit14 (bit6 if 8-bit) on second leading
// - Master drives 8/16 clocks per write
// - Slave output driven only while selected
// - Slave sends 8/16 bits MSB first, completes on count
// - Echo: no valid data, input retransmitted
// - No echo: shifter contents always sent
// - Interrupt on full, not busy, overrun
// - Busy set on start, clears on handoff
// - Data read clears full unless reloaded
// - Overrun cleared by writing one
// - Clock divisor is 2*(divider+1)
`timescale 1ns/1ns
module sync_serial_port (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        srst,
	// Register port
	input  wire logic [23:0] addr,
	input  wire logic [15:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [15:0] rdata,
	// Shift clock pin
	input  wire logic        shift_clock_pin_in,
	output logic             shift_clock_pin_out,
	output logic             shift_clock_pin_oe,
	// Master-out/slave-in pin
	input  wire logic        master_out_slave_in_pin_in,
	output logic             master_out_slave_in_pin_out,
	output logic             master_out_slave_in_pin_oe,
	// Master-in/slave-out pin
	input  wire logic        master_in_slave_out_pin_in,
	output logic             master_in_slave_out_pin_out,
	output logic             master_in_slave_out_pin_oe,
	// Slave select
	input  wire logic        slave_select_n,
	// Interrupt request
	output logic             irq
);

	// ==========================================================
	// Registers and wires
	logic [15:0]                   serial_control_ff;
	logic [15:0]                   shifter_ff;
	logic [15:0]                   read_buffer_ff;
	logic [15:0]                   rdata_ff;
	logic                          shifter_busy_ff;
	logic                          read_buffer_full_ff;
	logic                          overrun_flag_ff;
	logic                          rx_pending_ff;
	logic                          data_valid_ff;
	logic                          tx_bit_ff;
	logic                          sample_bit_ff;
	logic                          sample_pend_ff;
	logic [4:0]                    sample_cnt_ff;
	logic [4:0]                    edge_cnt_ff;
	logic                          sck_level_ff;
	logic                          sck_prev_ff;
	logic                          echo_active_ff;
	logic                          miso_out_ff;
	logic                          miso_oe_ff;
	logic                          mosi_oe_ff;
	logic                          sck_oe_ff;
	logic                          irq_ff;
	logic                          done_ff;
	serial_port_pkg::master_state_t state_ff;

	logic       port_enable;
	logic       master_mode;
	logic       wide_mode;
	logic       out_on_lead;
	logic       idle_level;
	logic [4:0] bit_len;
	logic [2:0] sync_level;
	logic       sck_s;
	logic       mosi_s;
	logic       cs_n_s;
	logic       in_bit;
	logic       tick;
	logic       edge_any;
	logic       edge_lead;
	logic       sample_edge;
	logic       shift_edge;
	logic       last_sample;
	logic       done;
	logic       data_wr;
	logic       data_rd;
	logic       ctrl_wr;
	logic       stat_wr;
	logic       slave_active;
	logic       xfer_start;

	// ==========================================================
	// Control decode
	assign port_enable = serial_control_ff[serial_port_pkg::PORT_ENABLE_BIT];
	assign master_mode = serial_control_ff[serial_port_pkg::MASTER_SELECT_BIT];
	assign wide_mode   = serial_control_ff[serial_port_pkg::WIDE_MODE_BIT];
	assign idle_level  = serial_control_ff[serial_port_pkg::CLOCK_IDLE_BIT];
	// output edge is leading when idle level and mode differ
	assign out_on_lead = idle_level ^ serial_control_ff[serial_port_pkg::CLOCK_EDGE_SEL_BIT];
	assign bit_len     = wide_mode ? serial_port_pkg::BITS_WIDE : serial_port_pkg::BITS_NARROW;

	// Bus strobes
	assign data_wr = wr && (addr == serial_port_pkg::SHIFT_DATA_ADDR);
	assign ctrl_wr = wr && (addr == serial_port_pkg::CONTROL_ADDR);
	assign stat_wr = wr && (addr == serial_port_pkg::STATUS_ADDR);
	assign data_rd = rd && (addr == serial_port_pkg::SHIFT_DATA_ADDR);

	// ==========================================================
	// Input synchronisers
	// slave clock, select and data pass the filter
	pin_sync u_sync (
		.clk       (clk),
		.srst      (srst),
		.pin_in    ({slave_select_n, master_out_slave_in_pin_in, shift_clock_pin_in}),
		.rst_level (3'h4),
		.level     (sync_level)
	);

	assign sck_s  = sync_level[0];
	assign mosi_s = sync_level[1];
	assign cs_n_s = sync_level[2];

	assign in_bit = master_mode ? master_in_slave_out_pin_in : mosi_s;

	// ==========================================================
	// Master shift clock
	// divider sets half period
	shift_clock_gen u_clkgen (
		.clk     (clk),
		.srst    (srst),
		.run     (state_ff == serial_port_pkg::ST_RUN),
		.divider (serial_control_ff[serial_port_pkg::DIVIDER_MSB:serial_port_pkg::DIVIDER_LSB]),
		.tick    (tick)
	);

	// master runs 2*len half periods per write
	always_ff @(posedge clk) begin
		if (srst || !port_enable || !master_mode) begin
			state_ff     <= serial_port_pkg::ST_IDLE;
			edge_cnt_ff  <= 5'h00;
			sck_level_ff <= idle_level;
		end else begin
			case (state_ff)
				serial_port_pkg::ST_IDLE: begin
					sck_level_ff <= idle_level;
					edge_cnt_ff  <= 5'h00;
					if (data_wr) begin
						state_ff <= serial_port_pkg::ST_RUN;
					end
				end
				serial_port_pkg::ST_RUN: begin
					if (tick) begin
						sck_level_ff <= ~sck_level_ff;
						edge_cnt_ff  <= edge_cnt_ff + 5'h01;
						if (edge_cnt_ff == {bit_len[3:0], 1'b0} - 5'h01) begin
							state_ff <= serial_port_pkg::ST_IDLE;
						end
					end
				end
				default: begin
					state_ff <= serial_port_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Slave clock edge history
	always_ff @(posedge clk) begin
		if (srst) begin
			sck_prev_ff <= 1'b0;
		end else begin
			sck_prev_ff <= sck_s;
		end
	end

	// ==========================================================
	// Edge classification
	// slave acts only on master clock while selected
	assign slave_active = port_enable && !master_mode && !cs_n_s;
	always_comb begin
		edge_any  = 1'b0;
		edge_lead = 1'b0;
		if (port_enable && master_mode) begin
			edge_any  = tick && (state_ff == serial_port_pkg::ST_RUN);
			edge_lead = sck_level_ff == idle_level;
		end else if (slave_active) begin
			edge_any  = sck_s != sck_prev_ff;
			edge_lead = sck_prev_ff == idle_level;
		end
	end

	// shift on output edge, sample on the other
	assign shift_edge  = edge_any && (edge_lead == out_on_lead);
	assign sample_edge = edge_any && (edge_lead != out_on_lead);
	assign last_sample = sample_cnt_ff == bit_len - 5'h01;
	assign done = (sample_edge && out_on_lead && last_sample) ||
		(shift_edge && !out_on_lead && sample_cnt_ff == bit_len);
	assign xfer_start = slave_active && edge_any && edge_lead && sample_cnt_ff == 5'h00 && !sample_pend_ff;

	// Completion one cycle late, once the last bit sits in the shifter
	always_ff @(posedge clk) begin
		done_ff <= done && !srst;
	end

	// ==========================================================
	// Bit counter
	// deselect realigns the count
	always_ff @(posedge clk) begin
		if (srst || !port_enable || data_wr || done || (!master_mode && cs_n_s)) begin
			sample_cnt_ff <= 5'h00;
		end else if (sample_edge) begin
			sample_cnt_ff <= sample_cnt_ff + 5'h01;
		end
	end

	// ==========================================================
	// Shifter
	always_ff @(posedge clk) begin
		if (srst) begin
			shifter_ff     <= serial_port_pkg::DATA_RESET;
			tx_bit_ff      <= 1'b0;
			sample_bit_ff  <= 1'b0;
			sample_pend_ff <= 1'b0;
		end else if (data_wr) begin
			shifter_ff     <= wdata;
			tx_bit_ff      <= wide_mode ? wdata[15] : wdata[7];
			sample_pend_ff <= 1'b0;
		end else if (!port_enable || (!master_mode && cs_n_s)) begin
			sample_pend_ff <= 1'b0;
			tx_bit_ff      <= wide_mode ? shifter_ff[15] : shifter_ff[7];
		end else if (sample_edge && out_on_lead && last_sample) begin
			// final sample shifts in at once
			sample_pend_ff <= 1'b0;
			if (wide_mode) begin
				shifter_ff <= {shifter_ff[14:0], in_bit};
			end else begin
				shifter_ff <= {shifter_ff[15:8], shifter_ff[6:0], in_bit};
			end
		end else if (sample_edge) begin
			sample_bit_ff  <= in_bit;
			sample_pend_ff <= 1'b1;
		end else if (shift_edge && sample_pend_ff) begin
			// first leading edge has no sample, so no shift
			// narrow mode shifts low byte only, MSB first
			sample_pend_ff <= 1'b0;
			if (wide_mode) begin
				shifter_ff <= {shifter_ff[14:0], sample_bit_ff};
				tx_bit_ff  <= shifter_ff[14];
			end else begin
				shifter_ff <= {shifter_ff[15:8], shifter_ff[6:0], sample_bit_ff};
				tx_bit_ff  <= shifter_ff[6];
			end
		end
	end

	// ==========================================================
	// Valid data and echo
	always_ff @(posedge clk) begin
		if (srst || !port_enable || done) begin
			data_valid_ff <= 1'b0;
		end else if (data_wr) begin
			data_valid_ff <= 1'b1;
		end
	end

	// echo fixed while a transfer runs
	always_ff @(posedge clk) begin
		if (srst || !slave_active || done) begin
			echo_active_ff <= 1'b0;
		end else if (sample_cnt_ff == 5'h00 && !sample_pend_ff) begin
			echo_active_ff <= serial_control_ff[serial_port_pkg::ECHO_ENABLE_BIT] && !data_valid_ff;
		end
	end

	// ==========================================================
	// Read buffer and full flag
	always_ff @(posedge clk) begin
		if (srst) begin
			read_buffer_ff      <= serial_port_pkg::DATA_RESET;
			read_buffer_full_ff <= 1'b0;
			rx_pending_ff       <= 1'b0;
		end else if (!port_enable) begin
			read_buffer_full_ff <= 1'b0;
			rx_pending_ff       <= 1'b0;
		end else if (done_ff && (!read_buffer_full_ff || (data_rd && !rx_pending_ff))) begin
			// load at completion when buffer free
			read_buffer_full_ff <= 1'b1;
			if (wide_mode) begin
				read_buffer_ff <= shifter_ff;
			end else begin
				read_buffer_ff[7:0] <= shifter_ff[7:0];
			end
		end else if (done_ff) begin
			rx_pending_ff <= 1'b1;
		end else if (data_rd && rx_pending_ff) begin
			// read reloads from shifter, full stays set
			rx_pending_ff <= 1'b0;
			if (wide_mode) begin
				read_buffer_ff <= shifter_ff;
			end else begin
				read_buffer_ff[7:0] <= shifter_ff[7:0];
			end
		end else if (data_rd) begin
			read_buffer_full_ff <= 1'b0;
		end
	end

	// ==========================================================
	// Busy flag
	// set wins over clear
	always_ff @(posedge clk) begin
		if (srst || !port_enable) begin
			shifter_busy_ff <= 1'b0;
		end else if (data_wr || xfer_start) begin
			shifter_busy_ff <= 1'b1;
		end else if (done_ff && (!read_buffer_full_ff || (data_rd && !rx_pending_ff))) begin
			shifter_busy_ff <= 1'b0;
		end else if (data_rd && rx_pending_ff) begin
			shifter_busy_ff <= 1'b0;
		end
	end

	// ==========================================================
	// Overrun flag
	always_ff @(posedge clk) begin
		if (srst || !port_enable) begin
			overrun_flag_ff <= 1'b0;
		end else if (data_wr && master_mode && read_buffer_full_ff && rx_pending_ff) begin
			// new start with both stores full
			overrun_flag_ff <= 1'b1;
		end else if (stat_wr && wdata[serial_port_pkg::OVERRUN_BIT]) begin
			overrun_flag_ff <= 1'b0;
		end
	end

	// ==========================================================
	// Control register
	always_ff @(posedge clk) begin
		if (srst) begin
			serial_control_ff <= serial_port_pkg::CONTROL_RESET;
		end else if (ctrl_wr) begin
			serial_control_ff <= wdata;
		end
	end

	// ==========================================================
	// Read data, valid only the cycle after a read
	always_ff @(posedge clk) begin
		if (srst || !rd) begin
			rdata_ff <= 16'h0000;
		end else begin
			case (addr)
				serial_port_pkg::SHIFT_DATA_ADDR: rdata_ff <= read_buffer_ff;
				serial_port_pkg::CONTROL_ADDR:    rdata_ff <= serial_control_ff;
				serial_port_pkg::STATUS_ADDR: begin
					rdata_ff <= {13'h0000, overrun_flag_ff, read_buffer_full_ff, shifter_busy_ff};
				end
				default: rdata_ff <= 16'h0000;
			endcase
		end
	end

	// ==========================================================
	// Pin drivers
	always_ff @(posedge clk) begin
		if (srst) begin
			miso_out_ff <= 1'b0;
			miso_oe_ff  <= 1'b0;
			mosi_oe_ff  <= 1'b0;
			sck_oe_ff   <= 1'b0;
		end else begin
			// echo input or send shifter bit
			miso_out_ff <= echo_active_ff ? mosi_s : tx_bit_ff;
			miso_oe_ff  <= slave_active;
			mosi_oe_ff  <= port_enable && master_mode;
			sck_oe_ff   <= port_enable && master_mode;
		end
	end

	// ==========================================================
	// Interrupt
	// three sources, overrun only as master
	always_ff @(posedge clk) begin
		if (srst || !port_enable) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= (read_buffer_full_ff && serial_control_ff[serial_port_pkg::READ_FULL_IRQ_BIT]) ||
				(!shifter_busy_ff && serial_control_ff[serial_port_pkg::XFER_DONE_IRQ_BIT]) ||
				(overrun_flag_ff && master_mode && serial_control_ff[serial_port_pkg::OVERRUN_IRQ_BIT]);
		end
	end

	// Outputs straight from flops
	assign rdata                       = rdata_ff;
	assign shift_clock_pin_out         = sck_level_ff;
	assign shift_clock_pin_oe          = sck_oe_ff;
	assign master_out_slave_in_pin_out = tx_bit_ff;
	assign master_out_slave_in_pin_oe  = mosi_oe_ff;
	assign master_in_slave_out_pin_out = miso_out_ff;
	assign master_in_slave_out_pin_oe  = miso_oe_ff;
	assign irq                         = irq_ff;

endmodule

// ---- hdl/serial_port_pkg.sv ----
// Shared constants for the synchronous serial port
package serial_port_pkg;

	// ==========================================================
	// Register map
	localparam int          ADDR_W          = 24;
	localparam int          DATA_W          = 16;
	localparam logic [23:0] SHIFT_DATA_ADDR = 24'hFFFE60;
	localparam logic [23:0] CONTROL_ADDR    = 24'hFFFE62;
	localparam logic [23:0] STATUS_ADDR     = 24'hFFFE64;

	// ==========================================================
	// Control field positions
	localparam int PORT_ENABLE_BIT     = 0;
	localparam int MASTER_SELECT_BIT   = 1;
	localparam int WIDE_MODE_BIT       = 2;
	localparam int ECHO_ENABLE_BIT     = 3;
	localparam int OVERRUN_IRQ_BIT     = 4;
	localparam int READ_FULL_IRQ_BIT   = 5;
	localparam int XFER_DONE_IRQ_BIT   = 6;
	localparam int CLOCK_EDGE_SEL_BIT  = 7;
	localparam int CLOCK_IDLE_BIT      = 8;
	localparam int DIVIDER_LSB         = 9;
	localparam int DIVIDER_MSB         = 15;

	// ==========================================================
	// Status field positions
	localparam int SHIFTER_BUSY_BIT    = 0;
	localparam int READ_FULL_BIT       = 1;
	localparam int OVERRUN_BIT         = 2;

	// ==========================================================
	// Reset values and counts
	localparam logic [15:0] CONTROL_RESET   = 16'h0000;
	localparam logic [15:0] DATA_RESET      = 16'h0000;
	localparam logic [4:0]  BITS_NARROW     = 5'h08;
	localparam logic [4:0]  BITS_WIDE       = 5'h10;
	localparam int          SYNC_STAGES     = 3;

	// Master clock generator states
	typedef enum logic [0:0] {
		ST_IDLE,
		ST_RUN
	} master_state_t;

endpackage

// ---- hdl/pin_sync.sv ----
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
module pin_sync (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       srst,
	// Raw and filtered levels
	input  wire logic [2:0] pin_in,
	input  wire logic [2:0] rst_level,
	output logic      [2:0] level
);

	// ==========================================================
	// One filtered chain per pin
	genvar i;
	generate
		for (i = 0; i < 3; i++) begin : g_pin
			logic s1_ff;
			logic s2_ff;
			logic s3_ff;
			logic lvl_ff;

			// First stage feeds only the second
			always_ff @(posedge clk) begin
				s1_ff <= pin_in[i];
				s2_ff <= s1_ff;
				s3_ff <= s2_ff;
			end

			// Change accepted once stages two and three agree
			always_ff @(posedge clk) begin
				if (srst) begin
					lvl_ff <= rst_level[i];
				end else if (s2_ff == s3_ff) begin
					lvl_ff <= s3_ff;
				end
			end

			assign level[i] = lvl_ff;
		end
	endgenerate

endmodule

// ---- hdl/shift_clock_gen.sv ----
// Master shift clock half-period tick generator
`timescale 1ns/1ns
module shift_clock_gen (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       srst,
	// Control
	input  wire logic       run,
	input  wire logic [6:0] divider,
	// Half-period pulse
	output logic            tick
);

	logic [6:0] cnt_ff;
	logic       tick_ff;

	// Pulse every divider+1 cycles, so a full period is 2*(divider+1)
	always_ff @(posedge clk) begin
		if (srst || !run) begin
			cnt_ff  <= 7'h00;
			tick_ff <= 1'b0;
		end else if (cnt_ff == divider) begin
			cnt_ff  <= 7'h00;
			tick_ff <= 1'b1;
		end else begin
			cnt_ff  <= cnt_ff + 7'h01;
			tick_ff <= 1'b0;
		end
	end

	assign tick = tick_ff;

endmodule

// ---- verification/serial_port_sva.sv ----
// Port-level assertions for the serial port, bound to its top module
`timescale 1ns/1ns
module serial_port_sva (
	// Clock and reset
	input wire logic        clk,
	input wire logic        srst,
	// Register port
	input wire logic [23:0] addr,
	input wire logic [15:0] wdata,
	input wire logic        wr,
	input wire logic        rd,
	input wire logic [15:0] rdata,
	// Pins and interrupt
	input wire logic        shift_clock_pin_out,
	input wire logic        shift_clock_pin_oe,
	input wire logic        master_out_slave_in_pin_oe,
	input wire logic        master_in_slave_out_pin_oe,
	input wire logic        slave_select_n,
	input wire logic        irq
);
	// ==========================================================
	// Control shadow and shift clock edge tracking
	logic [15:0] ctl_ff;
	logic        sck_q_ff;
	logic [5:0]  tog_ff;
	logic [7:0]  gap_ff;
	logic        chg;
	logic        ctl_wr;
	logic        mst;
	assign ctl_wr = wr && addr == serial_port_pkg::CONTROL_ADDR;
	assign chg    = shift_clock_pin_out != sck_q_ff;
	assign mst    = ctl_ff[0] && ctl_ff[1];
	// Copy of the control register
	always_ff @(posedge clk) begin
		if (srst)
			ctl_ff <= serial_port_pkg::CONTROL_RESET;
		else if (ctl_wr)
			ctl_ff <= wdata;
	end
	// Toggles since last write, cycles since last toggle
	always_ff @(posedge clk) begin
		sck_q_ff <= shift_clock_pin_out;
		if (srst || ctl_wr || (wr && addr == serial_port_pkg::SHIFT_DATA_ADDR))
			tog_ff <= 6'h00;
		else if (chg)
			tog_ff <= tog_ff + 6'h01;
		if (srst || chg)
			gap_ff <= 8'h01;
		else if (gap_ff != 8'hFF)
			gap_ff <= gap_ff + 8'h01;
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);
	sequence ctl_read;
		rd && addr == serial_port_pkg::CONTROL_ADDR;
	endsequence
	sequence stat_read;
		rd && addr == serial_port_pkg::STATUS_ADDR;
	endsequence

	rdata_idle_a: assert property (!$past(rd) |-> rdata == 16'h0000)
		else $error("read data not zero outside read slot");
	ctl_readback_a: assert property (ctl_read |=> rdata == $past(ctl_ff))
		else $error("control read differs from last write");
	status_rsvd_a: assert property (stat_read |=> rdata[15:3] == 13'h0000)
		else $error("status upper bits not zero");
	unmapped_read_a: assert property (rd && addr != serial_port_pkg::SHIFT_DATA_ADDR
		&& addr != serial_port_pkg::CONTROL_ADDR && addr != serial_port_pkg::STATUS_ADDR |=> rdata == 16'h0000)
		else $error("unmapped read returned data");
	master_oe_a: assert property ($stable(ctl_ff) |-> shift_clock_pin_oe == mst
		&& master_out_slave_in_pin_oe == mst)
		else $error("master pin enables wrong");
	role_excl_a: assert property ($stable(ctl_ff) && ctl_ff[1] |-> !master_in_slave_out_pin_oe)
		else $error("slave output driven in master mode");
	miso_release_a: assert property (slave_select_n [*6] |-> !master_in_slave_out_pin_oe)
		else $error("slave output driven while deselected");
	clk_count_a: assert property (mst |-> tog_ff <= (ctl_ff[2] ? 6'h20 : 6'h10))
		else $error("too many shift clock edges");
	clk_gap_a: assert property (chg && tog_ff != 6'h00 && mst |-> gap_ff == {1'b0, ctl_ff[15:9]} + 8'h01)
		else $error("shift clock half period wrong");
	irq_quiet_a: assert property (ctl_ff[6:4] == 3'h0 && $past(ctl_ff[6:4]) == 3'h0 |-> !irq)
		else $error("interrupt with all enables off");
endmodule

bind sync_serial_port serial_port_sva serial_port_sva_i (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata),
	.wr(wr), .rd(rd), .rdata(rdata), .shift_clock_pin_out(shift_clock_pin_out),
	.shift_clock_pin_oe(shift_clock_pin_oe), .master_out_slave_in_pin_oe(master_out_slave_in_pin_oe),
	.master_in_slave_out_pin_oe(master_in_slave_out_pin_oe), .slave_select_n(slave_select_n), .irq(irq));

// ---- verification/far_peer_model.sv ----
// Behavioural far-side slave that answers the port in master mode
`timescale 1ns/1ns
module far_peer_model (
	// Serial link
	input  wire logic        sck,
	input  wire logic        mosi,
	output logic             miso,
	// Set-up from the bench
	input  wire logic        sel,
	input  wire logic        alt,
	input  wire logic        idle,
	input  wire logic        wide,
	input  wire logic        load,
	input  wire logic [15:0] reply,
	output logic      [15:0] rx
);
	logic [15:0] tx_ff;
	logic        first_ff;
	// Released line shows the inverse of the last bit
	assign miso = sel ? tx_ff[15] : ~tx_ff[15];
	// shift only on the received clock
	always @(posedge load or posedge sck or negedge sck) begin
		if (load) begin
			tx_ff    <= wide ? reply : {reply[7:0], 8'h00};
			rx       <= 16'h0000;
			first_ff <= 1'b1;
		end else if (sel && sck == alt) begin
			if (!(first_ff && alt != idle))
				tx_ff <= tx_ff << 1;
			first_ff <= 1'b0;
		end else if (sel)
			rx <= {rx[14:0], mosi};
	end
endmodule

// ---- verification/tb_top.sv ----
// Self-checking bench for the synchronous serial port
`timescale 1ns/1ns
module tb_top;
	localparam logic [6:0]  DIV   = 7'h01;
	localparam logic [23:0] DAT_A = serial_port_pkg::SHIFT_DATA_ADDR;
	localparam logic [23:0] CTL_A = serial_port_pkg::CONTROL_ADDR;
	localparam logic [23:0] STA_A = serial_port_pkg::STATUS_ADDR;
	logic        clk = 1'b0;
	logic        srst = 1'b1;
	logic [23:0] addr = 24'h000000;
	logic [15:0] wdata = 16'h0000;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic        tb_sck = 1'b0;
	logic        tb_mosi = 1'b0;
	logic        ss_n = 1'b1;
	logic        sel = 1'b0;
	logic        alt = 1'b0;
	logic        idle = 1'b0;
	logic        wide = 1'b0;
	logic        load = 1'b0;
	logic [15:0] reply = 16'h0000;
	logic [15:0] rdata, rx, rv, last_rp;
	logic        sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe, irq;
	logic        sck_w, mosi_w, miso_w, peer_miso;
	int          n_fail = 0;
	int          n_tests = 0;
	int          nb = 8;

	// Clock and wire levels from the port's enables, else bench or peer
	always #5 clk = ~clk;
	assign sck_w  = sck_oe ? sck_out : tb_sck;
	assign mosi_w = mosi_oe ? mosi_out : tb_mosi;
	assign miso_w = miso_oe ? miso_out : peer_miso;

	sync_serial_port sync_serial_port_i (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .shift_clock_pin_in(sck_w), .shift_clock_pin_out(sck_out),
		.shift_clock_pin_oe(sck_oe), .master_out_slave_in_pin_in(mosi_w),
		.master_out_slave_in_pin_out(mosi_out), .master_out_slave_in_pin_oe(mosi_oe),
		.master_in_slave_out_pin_in(miso_w), .master_in_slave_out_pin_out(miso_out),
		.master_in_slave_out_pin_oe(miso_oe), .slave_select_n(ss_n), .irq(irq));
	far_peer_model far_peer_model_i (.sck(sck_w), .mosi(mosi_w), .miso(peer_miso), .sel(sel), .alt(alt),
		.idle(idle), .wide(wide), .load(load), .reply(reply), .rx(rx));

	// ==========================================================
	// Shared tasks
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic bus_wr(input logic [23:0] a, input logic [15:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rchk(input logic [23:0] a, input logic [15:0] m, input logic [15:0] e);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 rv = rdata;
		check(rv & m, e);
	endtask
	task automatic cfg(input logic a, input logic i, input logic w, input logic [15:0] extra);
		alt  <= a;
		idle <= i;
		wide <= w;
		nb = w ? 16 : 8;
		bus_wr(CTL_A, extra | {DIV, i, a, 4'h0, w, 2'b11});
		repeat (4) @(posedge clk);
		check({15'h0000, sck_out}, {15'h0000, i});
	endtask
	task automatic mx(input logic [15:0] rep, input logic [15:0] d);
		reply <= rep;
		sel   <= 1'b1;
		load  <= 1'b1;
		@(posedge clk);
		load <= 1'b0;
		bus_wr(DAT_A, d);
		repeat (2 * nb * (DIV + 1) + 16) @(posedge clk);
		sel <= 1'b0;
		check({15'h0000, sck_out}, {15'h0000, idle});
		check(nb == 16 ? rx : {8'h00, rx[7:0]}, nb == 16 ? d : {8'h00, d[7:0]});
	endtask
	task automatic irq_is(input logic e);
		check({15'h0000, irq}, {15'h0000, e});
	endtask

	// ==========================================================
	// Scenarios
	task automatic regs();
		rchk(CTL_A, 16'hFFFF, serial_port_pkg::CONTROL_RESET);
		rchk(STA_A, 16'hFFFF, 16'h0000);
		rchk(DAT_A, 16'hFFFF, serial_port_pkg::DATA_RESET);
		bus_wr(24'hFFFE66, 16'hFFFF);
		rchk(24'hFFFE66, 16'hFFFF, 16'h0000);
		bus_wr(CTL_A, 16'h0041);
		rchk(CTL_A, 16'hFFFF, 16'h0041);
		irq_is(1'b1);
		bus_wr(CTL_A, 16'h0000);
	endtask
	task automatic modes();
		for (int k = 0; k < 4; k++) begin
			last_rp = 16'h9C31 ^ {4{k[3:0]}};
			cfg(k[0], k[1], 1'b1, 16'h0020);
			mx(last_rp, ~last_rp);
			rchk(STA_A, 16'hFFFF, 16'h0002);
			irq_is(1'b1);
			rchk(DAT_A, 16'hFFFF, last_rp);
			rchk(STA_A, 16'hFFFF, 16'h0000);
			irq_is(1'b0);
		end
	endtask
	task automatic overrun();
		cfg(1'b0, 1'b0, 1'b0, 16'h0010);
		mx(16'h003C, 16'h0081);
		mx(16'h00C3, 16'h0042);
		rchk(STA_A, 16'hFFFF, 16'h0003);
		irq_is(1'b0);
		rchk(DAT_A, 16'hFFFF, {last_rp[15:8], 8'h3C});
		rchk(STA_A, 16'hFFFF, 16'h0002);
		rchk(DAT_A, 16'hFFFF, {last_rp[15:8], 8'hC3});
		mx(16'h0011, 16'h0001);
		mx(16'h0022, 16'h0002);
		mx(16'h0033, 16'h0003);
		rchk(STA_A, 16'h0004, 16'h0004);
		irq_is(1'b1);
		bus_wr(STA_A, 16'h0003);
		rchk(STA_A, 16'h0004, 16'h0004);
		bus_wr(STA_A, 16'h0004);
		rchk(STA_A, 16'h0004, 16'h0000);
		bus_wr(CTL_A, 16'h0000);
	endtask
	task automatic slv(input logic echo, input logic w, input logic [15:0] tx, input logic [15:0] mo);
		int n;
		n = w ? 16 : 8;
		bus_wr(CTL_A, {12'h000, echo, w, 2'b01});
		if (!echo)
			bus_wr(DAT_A, tx);
		repeat (8) @(posedge clk);
		check({15'h0000, miso_oe}, 16'h0000);
		ss_n <= 1'b0;
		repeat (8) @(posedge clk);
		check({15'h0000, miso_oe}, 16'h0001);
		for (int i = n - 1; i >= 0; i--) begin
			tb_mosi <= mo[i];
			repeat (8) @(posedge clk);
			check({15'h0000, miso_w}, {15'h0000, echo ? mo[i] : tx[i]});
			tb_sck <= 1'b1;
			repeat (8) @(posedge clk);
			tb_sck <= 1'b0;
		end
		repeat (8) @(posedge clk);
		ss_n    <= 1'b1;
		tb_mosi <= ~tb_mosi;
		rchk(STA_A, 16'hFFFF, 16'h0002);
		rchk(DAT_A, w ? 16'hFFFF : 16'h00FF, w ? mo : {8'h00, mo[7:0]});
		bus_wr(CTL_A, 16'h0000);
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d, mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Main sequence after an eight-cycle reset
	initial begin
		repeat (8) @(posedge clk);
		srst <= 1'b0;
		regs();
		modes();
		overrun();
		slv(1'b1, 1'b0, 16'h0000, 16'h00B4);
		slv(1'b0, 1'b1, 16'hA55A, 16'h3C96);
		report_and_stop();
	end
	// Watchdog well beyond the expected run
	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		report_and_stop();
	end
endmodule
